// ---- logic/cgs_params.svh ----
`ifndef CGS_PARAMS_SVH
`define CGS_PARAMS_SVH

// register byte offsets
`define CGS_SYSCTL_OFS 8'h00
`define CGS_OSCCTL_OFS 8'h04
`define CGS_STBYCTL_OFS 8'h08
`define CGS_IDLECTL_OFS 8'h0C
`define CGS_STATUS_OFS 8'h10
`define CGS_WARMUP_OFS 8'h14

// field positions
`define CGS_GEAR_LSB 0
`define CGS_PRCK_LSB 8
`define CGS_PERIPHERAL_CLOCK_SOURCE_SELECT_BIT 12
`define CGS_MULTIPLIER_LOOP_ENABLE_BIT 0
`define CGS_PLLSEL_BIT 1
`define CGS_STBY_LSB 0
`define CGS_DRIVE_BIT 16
`define CGS_MODE_LSB 0
`define CGS_AGEAR_LSB 4
`define CGS_APRCK_LSB 8

// standby codes
`define CGS_STBY_STOP 3'h1
`define CGS_STBY_IDLE 3'h3

// reset values
`define CGS_GEAR_RST 3'h0
`define CGS_PRCK_RST 3'h0
`define CGS_STBY_RST 3'h0
`define CGS_IDLE_EN_RST 4'h0
`define CGS_WARMUP_RST 12'h010

// gear and prescaler limits (log2 of the ratio)
`define CGS_GEAR_MAX 3'h4
`define CGS_PRCK_MAX 3'h5

// oscillator period in fast cycles while the multiplier loop is bypassed
`define CGS_PLL_MULT 8

`endif

// ---- logic/cgs_pkg.sv ----
`default_nettype none

package cgs_pkg;

  typedef enum logic [1:0] {
    CGS_NORMAL,
    CGS_IDLE,
    CGS_STOP,
    CGS_WARM
  } cgs_mode_t;

  typedef struct packed {
    logic peripheral_clock_source_select;
    logic [2:0] prck;
    logic [2:0] gear;
  } cgs_sysctl_t;

  typedef struct packed {
    logic port_in_en;
    logic port_out_en_n;
    logic dbg_out_en_n;
    logic [5:0] motor_out_en_n;
    logic ctl_in_en;
    logic osc_in_en;
  } cgs_pins_t;

endpackage

`default_nettype wire

// ---- logic/cgs_div.sv ----
`timescale 1ns/10ps
`default_nettype none

module cgs_div #(
  parameter int CNT_W = 5
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic [2:0] sel_in,
  output logic tick_out,
  output logic [2:0] cur_sel_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'((1 << cur_sel_out) - 1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
      cur_sel_out <= 3'h0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_q == limit) begin
          cnt_q <= '0;
          tick_out <= 1'b1;
          cur_sel_out <= sel_in;
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/cgs_pin.sv ----
`timescale 1ns/10ps
`default_nettype none

module cgs_pin (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stop_in,
  input wire logic drive_in,
  input wire logic dbg_valid_in,
  input wire logic [5:0] motor_valid_in,
  output cgs_pkg::cgs_pins_t pins_out
);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_out <= '{1'b1, 1'b0, 1'b0, 6'h00, 1'b1, 1'b1};
    end else begin
      pins_out.port_in_en <= !stop_in || drive_in;
      pins_out.port_out_en_n <= stop_in && !drive_in;
      pins_out.dbg_out_en_n <= stop_in && !dbg_valid_in;
      pins_out.motor_out_en_n <= stop_in ? ~motor_valid_in : 6'h00;
      pins_out.ctl_in_en <= 1'b1;
      pins_out.osc_in_en <= !stop_in;
    end
  end

endmodule

`default_nettype wire

// ---- logic/cgs_top.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "cgs_params.svh"

module cgs_top #(
  parameter int ADDR_W = 8,
  parameter int WARM_W = 12
) (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // core handshake
  input wire logic WFI_IN,
  input wire logic WAKE_REQ_IN,
  // pin validity
  input wire logic DBG_VALID_IN,
  input wire logic [5:0] MOTOR_VALID_IN,
  // clock ticks and run enables
  output logic SYS_TICK_OUT,
  output logic PRESC_TICK_OUT,
  output logic CORE_RUN_OUT,
  output logic OSC_RUN_OUT,
  output logic [3:0] PERIPH_RUN_OUT,
  // pin controls
  output logic PORT_IN_EN_OUT,
  output logic PORT_OUT_EN_N_OUT,
  output logic DBG_OUT_EN_N_OUT,
  output logic [5:0] MOTOR_OUT_EN_N_OUT,
  output logic CTL_IN_EN_OUT,
  output logic OSC_IN_EN_OUT
);

  cgs_pkg::cgs_sysctl_t sysctl_q;
  cgs_pkg::cgs_mode_t mode_q;
  cgs_pkg::cgs_mode_t resume_q;
  cgs_pkg::cgs_pins_t pins;
  logic pll_on_q;
  logic pll_sel_q;
  logic [2:0] stby_q;
  logic drive_q;
  logic [3:0] idle_en_q;
  logic [WARM_W-1:0] warmup_q;
  logic [WARM_W-1:0] warm_cnt_q;
  logic [2:0] osc_cnt_q;
  logic osc_tick;
  logic src_tick;
  logic clk_live;
  logic [2:0] gear_sel;
  logic [2:0] prck_sel;
  logic gear_tick;
  logic presc_tick;
  logic presc_src;
  logic [2:0] act_gear;
  logic [2:0] act_prck;
  logic wr_sys;
  logic wr_osc;
  logic wr_stby;
  logic wr_idle;
  logic wr_warm;

  assign wr_sys = WR_IN && (ADDR_IN == `CGS_SYSCTL_OFS);
  assign wr_osc = WR_IN && (ADDR_IN == `CGS_OSCCTL_OFS);
  assign wr_stby = WR_IN && (ADDR_IN == `CGS_STBYCTL_OFS);
  assign wr_idle = WR_IN && (ADDR_IN == `CGS_IDLECTL_OFS);
  assign wr_warm = WR_IN && (ADDR_IN == `CGS_WARMUP_OFS);

  // system control fields
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sysctl_q.gear <= `CGS_GEAR_RST;
      sysctl_q.prck <= `CGS_PRCK_RST;
      sysctl_q.peripheral_clock_source_select <= 1'b0;
    end else if (wr_sys) begin
      sysctl_q.gear <= WDATA_IN[`CGS_GEAR_LSB +: 3];
      sysctl_q.prck <= WDATA_IN[`CGS_PRCK_LSB +: 3];
      sysctl_q.peripheral_clock_source_select <= WDATA_IN[`CGS_PERIPHERAL_CLOCK_SOURCE_SELECT_BIT];
    end
  end

  // oscillator control
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pll_on_q <= 1'b0;
      pll_sel_q <= 1'b0;
    end else if (wr_osc) begin
      pll_on_q <= WDATA_IN[`CGS_MULTIPLIER_LOOP_ENABLE_BIT];
      pll_sel_q <= WDATA_IN[`CGS_PLLSEL_BIT];
    end
  end

  // standby control
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      stby_q <= `CGS_STBY_RST;
      drive_q <= 1'b0;
    end else if (wr_stby) begin
      stby_q <= WDATA_IN[`CGS_STBY_LSB +: 3];
      drive_q <= WDATA_IN[`CGS_DRIVE_BIT];
    end
  end

  // idle-run enables: timer, serial, watchdog, vector engine
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      idle_en_q <= `CGS_IDLE_EN_RST;
    end else if (wr_idle) begin
      idle_en_q <= WDATA_IN[3:0];
    end
  end

  // warm-up length in oscillator periods
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      warmup_q <= WARM_W'(`CGS_WARMUP_RST);
    end else if (wr_warm) begin
      warmup_q <= WDATA_IN[WARM_W-1:0];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RDATA_OUT <= 32'h0000_0000;
    end else begin
      RDATA_OUT <= 32'h0000_0000;
      if (RD_IN) begin
        unique case (ADDR_IN)
          `CGS_SYSCTL_OFS: begin
            RDATA_OUT[`CGS_GEAR_LSB +: 3] <= sysctl_q.gear;
            RDATA_OUT[`CGS_PRCK_LSB +: 3] <= sysctl_q.prck;
            RDATA_OUT[`CGS_PERIPHERAL_CLOCK_SOURCE_SELECT_BIT] <= sysctl_q.peripheral_clock_source_select;
          end
          `CGS_OSCCTL_OFS: begin
            RDATA_OUT[`CGS_MULTIPLIER_LOOP_ENABLE_BIT] <= pll_on_q;
            RDATA_OUT[`CGS_PLLSEL_BIT] <= pll_sel_q;
          end
          `CGS_STBYCTL_OFS: begin
            RDATA_OUT[`CGS_STBY_LSB +: 3] <= stby_q;
            RDATA_OUT[`CGS_DRIVE_BIT] <= drive_q;
          end
          `CGS_IDLECTL_OFS: begin
            RDATA_OUT[3:0] <= idle_en_q;
          end
          `CGS_STATUS_OFS: begin
            RDATA_OUT[`CGS_MODE_LSB +: 2] <= mode_q;
            RDATA_OUT[`CGS_AGEAR_LSB +: 3] <= act_gear;
            RDATA_OUT[`CGS_APRCK_LSB +: 3] <= act_prck;
          end
          `CGS_WARMUP_OFS: begin
            RDATA_OUT[WARM_W-1:0] <= warmup_q;
          end
          default: begin
            RDATA_OUT <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // mode sequencer
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mode_q <= cgs_pkg::CGS_NORMAL;
      resume_q <= cgs_pkg::CGS_NORMAL;
    end else begin
      unique case (mode_q)
        cgs_pkg::CGS_NORMAL: begin
          if (WFI_IN) begin
            if (stby_q == `CGS_STBY_STOP) begin
              mode_q <= cgs_pkg::CGS_STOP;
              resume_q <= cgs_pkg::CGS_NORMAL;
            end else if (stby_q == `CGS_STBY_IDLE) begin
              mode_q <= cgs_pkg::CGS_IDLE;
            end
          end
        end
        cgs_pkg::CGS_IDLE: begin
          if (WAKE_REQ_IN) begin
            mode_q <= cgs_pkg::CGS_NORMAL;
          end
        end
        cgs_pkg::CGS_STOP: begin
          if (WAKE_REQ_IN) begin
            mode_q <= cgs_pkg::CGS_WARM;
          end
        end
        cgs_pkg::CGS_WARM: begin
          if (warm_cnt_q == warmup_q) begin
            mode_q <= resume_q;
          end
        end
      endcase
    end
  end

  // warm-up counts oscillator periods after stop release
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      warm_cnt_q <= '0;
    end else if (mode_q != cgs_pkg::CGS_WARM) begin
      warm_cnt_q <= '0;
    end else if (osc_tick && warm_cnt_q != warmup_q) begin
      warm_cnt_q <= warm_cnt_q + WARM_W'(1);
    end
  end

  // raw oscillator: one tick per multiplier ratio of fast cycles
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      osc_cnt_q <= 3'h0;
    end else if (mode_q == cgs_pkg::CGS_STOP) begin
      osc_cnt_q <= 3'h0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 3'h1;
    end
  end

  assign osc_tick = (mode_q != cgs_pkg::CGS_STOP) &&
    (osc_cnt_q == 3'(`CGS_PLL_MULT - 1));

  // clocks stop in stop and during warm-up
  assign clk_live = (mode_q == cgs_pkg::CGS_NORMAL) ||
    (mode_q == cgs_pkg::CGS_IDLE);

  // multiplier loop gives eight ticks per oscillator period
  assign src_tick = clk_live && ((pll_on_q && pll_sel_q) ? 1'b1 : osc_tick);

  assign gear_sel = (sysctl_q.gear > `CGS_GEAR_MAX) ? `CGS_GEAR_MAX : sysctl_q.gear;
  assign prck_sel = (sysctl_q.prck > `CGS_PRCK_MAX) ? `CGS_PRCK_MAX : sysctl_q.prck;

  cgs_div #(
    .CNT_W(5)
  ) u_gear (
    .clk_in(CLOCK_IN),
    .rst_n_in(ARST_N_IN),
    .tick_in(src_tick),
    .sel_in(gear_sel),
    .tick_out(gear_tick),
    .cur_sel_out(act_gear)
  );

  // peripheral clock is gear output or undivided source
  assign presc_src = sysctl_q.peripheral_clock_source_select ? gear_tick : src_tick;

  cgs_div #(
    .CNT_W(6)
  ) u_presc (
    .clk_in(CLOCK_IN),
    .rst_n_in(ARST_N_IN),
    .tick_in(presc_src),
    .sel_in(prck_sel),
    .tick_out(presc_tick),
    .cur_sel_out(act_prck)
  );

  // ticks and run enables, registered for clean outputs
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SYS_TICK_OUT <= 1'b0;
      PRESC_TICK_OUT <= 1'b0;
      CORE_RUN_OUT <= 1'b1;
      OSC_RUN_OUT <= 1'b1;
      PERIPH_RUN_OUT <= 4'hF;
    end else begin
      SYS_TICK_OUT <= gear_tick && clk_live;
      PRESC_TICK_OUT <= presc_tick && clk_live;
      OSC_RUN_OUT <= mode_q != cgs_pkg::CGS_STOP;
      // core halts in any low-power mode
      CORE_RUN_OUT <= mode_q == cgs_pkg::CGS_NORMAL;
      unique case (mode_q)
        cgs_pkg::CGS_NORMAL: PERIPH_RUN_OUT <= 4'hF;
        cgs_pkg::CGS_IDLE: PERIPH_RUN_OUT <= idle_en_q;
        cgs_pkg::CGS_STOP: PERIPH_RUN_OUT <= 4'h0;
        cgs_pkg::CGS_WARM: PERIPH_RUN_OUT <= 4'h0;
      endcase
    end
  end

  // pin states follow the stop mode
  cgs_pin u_pin (
    .clk_in(CLOCK_IN),
    .rst_n_in(ARST_N_IN),
    .stop_in(mode_q == cgs_pkg::CGS_STOP),
    .drive_in(drive_q),
    .dbg_valid_in(DBG_VALID_IN),
    .motor_valid_in(MOTOR_VALID_IN),
    .pins_out(pins)
  );

  // second stage keeps the top outputs on flops of their own
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PORT_IN_EN_OUT <= 1'b1;
      PORT_OUT_EN_N_OUT <= 1'b0;
      DBG_OUT_EN_N_OUT <= 1'b0;
      MOTOR_OUT_EN_N_OUT <= 6'h00;
      CTL_IN_EN_OUT <= 1'b1;
      OSC_IN_EN_OUT <= 1'b1;
    end else begin
      PORT_IN_EN_OUT <= pins.port_in_en;
      PORT_OUT_EN_N_OUT <= pins.port_out_en_n;
      DBG_OUT_EN_N_OUT <= pins.dbg_out_en_n;
      MOTOR_OUT_EN_N_OUT <= pins.motor_out_en_n;
      CTL_IN_EN_OUT <= pins.ctl_in_en;
      OSC_IN_EN_OUT <= pins.osc_in_en;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/cgs_top_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module cgs_top_checker (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic WFI_IN,
  input wire logic DBG_VALID_IN,
  input wire logic [5:0] MOTOR_VALID_IN,
  input wire logic SYS_TICK_OUT,
  input wire logic PRESC_TICK_OUT,
  input wire logic CORE_RUN_OUT,
  input wire logic OSC_RUN_OUT,
  input wire logic [3:0] PERIPH_RUN_OUT,
  input wire logic DBG_OUT_EN_N_OUT,
  input wire logic [5:0] MOTOR_OUT_EN_N_OUT,
  input wire logic CTL_IN_EN_OUT,
  input wire logic OSC_IN_EN_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  property p_stop_ticks;
    !OSC_RUN_OUT |-> !SYS_TICK_OUT && !PRESC_TICK_OUT;
  endproperty
  a_stop_ticks: assert property (p_stop_ticks)
    else $error("tick while oscillator stopped");
  property p_stop_run;
    !OSC_RUN_OUT |-> !CORE_RUN_OUT && PERIPH_RUN_OUT == 4'h0;
  endproperty
  a_stop_run: assert property (p_stop_run)
    else $error("core or peripheral running in stop");
  property p_normal_run;
    CORE_RUN_OUT |-> PERIPH_RUN_OUT == 4'hF && OSC_RUN_OUT;
  endproperty
  a_normal_run: assert property (p_normal_run)
    else $error("peripherals halted while core runs");
  // core only halts two cycles after a wait instruction
  property p_wfi_cause;
    $fell(CORE_RUN_OUT) |-> $past(WFI_IN, 2);
  endproperty
  a_wfi_cause: assert property (p_wfi_cause)
    else $error("core halted without wait instruction");
  property p_ctl_in;
    CTL_IN_EN_OUT;
  endproperty
  a_ctl_in: assert property (p_ctl_in)
    else $error("control inputs disabled");
  property p_osc_in;
    OSC_IN_EN_OUT == $past(OSC_RUN_OUT);
  endproperty
  a_osc_in: assert property (p_osc_in)
    else $error("oscillator input enable out of step");
  property p_dbg;
    !OSC_IN_EN_OUT |-> DBG_OUT_EN_N_OUT == !$past(DBG_VALID_IN, 2);
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug output enable wrong in stop");
  property p_motor;
    !OSC_IN_EN_OUT |-> MOTOR_OUT_EN_N_OUT == ~$past(MOTOR_VALID_IN, 2);
  endproperty
  a_motor: assert property (p_motor)
    else $error("motor output enable wrong in stop");
endmodule
bind cgs_top cgs_top_checker i_chk (
  .CLOCK_IN(CLOCK_IN),
  .ARST_N_IN(ARST_N_IN),
  .WFI_IN(WFI_IN),
  .DBG_VALID_IN(DBG_VALID_IN),
  .MOTOR_VALID_IN(MOTOR_VALID_IN),
  .SYS_TICK_OUT(SYS_TICK_OUT),
  .PRESC_TICK_OUT(PRESC_TICK_OUT),
  .CORE_RUN_OUT(CORE_RUN_OUT),
  .OSC_RUN_OUT(OSC_RUN_OUT),
  .PERIPH_RUN_OUT(PERIPH_RUN_OUT),
  .DBG_OUT_EN_N_OUT(DBG_OUT_EN_N_OUT),
  .MOTOR_OUT_EN_N_OUT(MOTOR_OUT_EN_N_OUT),
  .CTL_IN_EN_OUT(CTL_IN_EN_OUT),
  .OSC_IN_EN_OUT(OSC_IN_EN_OUT)
);
`default_nettype wire

// ---- testbench/tb_cgs_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); \
  end \
end
module tb_cgs_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wait_for_interrupt_instruction = 1'b0;
  logic wake = 1'b0;
  logic dbg_v = 1'b0;
  logic [5:0] mot_v = 6'h00;
  logic [31:0] rdata;
  logic sys_tk, pre_tk, core_run, osc_run, port_in, port_out_n, dbg_n, ctl_in, osc_in;
  logic [3:0] per_run;
  logic [5:0] mot_n;
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  cgs_top i_dut (
    .CLOCK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .WFI_IN(wait_for_interrupt_instruction), .WAKE_REQ_IN(wake),
    .DBG_VALID_IN(dbg_v), .MOTOR_VALID_IN(mot_v), .SYS_TICK_OUT(sys_tk),
    .PRESC_TICK_OUT(pre_tk), .CORE_RUN_OUT(core_run), .OSC_RUN_OUT(osc_run),
    .PERIPH_RUN_OUT(per_run), .PORT_IN_EN_OUT(port_in), .PORT_OUT_EN_N_OUT(port_out_n),
    .DBG_OUT_EN_N_OUT(dbg_n), .MOTOR_OUT_EN_N_OUT(mot_n), .CTL_IN_EN_OUT(ctl_in),
    .OSC_IN_EN_OUT(osc_in)
  );
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  // one-cycle pulse on the wake pin when w is set, else on the wait pin
  task automatic pulse(input logic w);
    @(posedge clk);
    wake <= w;
    wait_for_interrupt_instruction <= !w;
    @(posedge clk);
    wake <= 1'b0;
    wait_for_interrupt_instruction <= 1'b0;
  endtask
  // cycles between two ticks, bounded so a dead divider cannot hang
  task automatic per(input logic p, input int e);
    int n;
    n = 0;
    @(negedge clk);
    while ((p ? pre_tk : sys_tk) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((p ? pre_tk : sys_tk) !== 1'b1 && n < 300);
    `CHK(n, e)
  endtask
  task automatic set_div(input logic [31:0] v, input logic p, input int e);
    wr_reg(8'h00, v);
    repeat (80) @(posedge clk);
    per(p, e);
  endtask
  task automatic stop_run(input logic d);
    // warm-up set while still in normal
    wr_reg(8'h14, 32'h0000_0010);
    rd_chk(8'h14, 32'h0000_0010);
    wr_reg(8'h08, {15'h0000, d, 16'h0001});
    rd_chk(8'h08, {15'h0000, d, 16'h0001});
    dbg_v <= 1'b1;
    mot_v <= 6'h2A;
    pulse(1'b0);
    repeat (4) @(posedge clk);
    #1;
    `CHK({osc_run, core_run, ctl_in, osc_in}, 4'h2)
    `CHK({port_in, port_out_n}, {d, !d})
    `CHK({dbg_n, mot_n}, 7'h15)
    @(posedge clk);
    dbg_v <= 1'b0;
    mot_v <= 6'h0F;
    repeat (3) @(posedge clk);
    #1;
    `CHK({dbg_n, mot_n}, 7'h70)
    rd_chk(8'h10, 32'h0000_0002);
    pulse(1'b1);
    // warm-up is 16 oscillator periods of 8 cycles
    repeat (100) @(posedge clk);
    #1;
    `CHK(core_run, 1'b0)
    rd_chk(8'h10, 32'h0000_0003);
    repeat (60) @(posedge clk);
    #1;
    `CHK(core_run, 1'b1)
    rd_chk(8'h10, 32'h0000_0000);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(8'h10, 32'hFFFF_FFFF);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++) begin
      rd_chk(8'(4 * i), (i == 5) ? 32'h0000_0010 : 32'h0000_0000);
    end
    `CHK({core_run, osc_run, per_run}, 6'h3F)
    per(1'b0, 8);
    $display("test reset done");
    // /16 with the multiplier still off
    set_div(32'h0000_0001, 1'b0, 16);
    wr_reg(8'h04, 32'h0000_0003);
    rd_chk(8'h04, 32'h0000_0003);
    for (int g = 0; g < 5; g++) begin
      set_div(32'(g), 1'b0, 1 << g);
      rd_chk(8'h10, 32'(g) << 4);
    end
    // prescaler ratios taken from the undivided source
    for (int p = 0; p < 6; p++) begin
      set_div(32'(p) << 8, 1'b1, 1 << p);
    end
    set_div(32'h0000_1101, 1'b1, 4);
    set_div(32'h0000_0000, 1'b0, 1);
    // select without enable keeps the raw oscillator
    wr_reg(8'h04, 32'h0000_0002);
    set_div(32'h0000_0000, 1'b0, 8);
    $display("test dividers done");
    wr_reg(8'h0C, 32'h0000_0009);
    rd_chk(8'h0C, 32'h0000_0009);
    wr_reg(8'h08, 32'h0000_0003);
    pulse(1'b0);
    repeat (3) @(posedge clk);
    #1;
    `CHK({core_run, osc_run, per_run}, 6'h19)
    rd_chk(8'h10, 32'h0000_0001);
    pulse(1'b1);
    repeat (3) @(posedge clk);
    #1;
    `CHK({core_run, per_run}, 5'h1F)
    for (int c = 0; c < 8; c++) begin
      if (c != 1 && c != 3) begin
        wr_reg(8'h08, 32'(c));
        pulse(1'b0);
        repeat (3) @(posedge clk);
        #1;
        `CHK(core_run, 1'b1)
      end
    end
    $display("test idle done");
    stop_run(1'b0);
    stop_run(1'b1);
    $display("test stop done");
    wr_reg(8'h08, 32'h0000_0003);
    pulse(1'b0);
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({core_run, per_run}, 5'h1F)
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h10, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0000);
    $display("test reset in idle done");
    results();
  end
endmodule
`undef CHK
`default_nettype wire
